/* File: src/adc_cfg_pkg.sv */
// Constants shared by the mode, pin and scan configuration bank
package adc_cfg_pkg;

    // ----------------------------------------------------------------
    // Serial frame layout
    // ----------------------------------------------------------------
    localparam int        FRAME_BITS  = 24;
    localparam int        CNT_W       = 5;
    localparam logic [4:0] CNT_HDR_END = 5'h0f;
    localparam logic [4:0] CNT_LAST    = 5'h17;
    localparam logic [7:0] CMD_WRITE   = 8'h08;
    localparam logic [7:0] CMD_READ    = 8'h10;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_OPMODE  = 8'h04;
    localparam logic [7:0] OFF_PIN     = 8'h05;
    localparam logic [7:0] OFF_DIR     = 8'h07;
    localparam logic [7:0] OFF_DRIVE   = 8'h09;
    localparam logic [7:0] OFF_LEVEL   = 8'h0b;
    localparam logic [7:0] OFF_INPUT   = 8'h0d;
    localparam logic [7:0] OFF_SCAN    = 8'h10;
    localparam logic [7:0] OFF_MANUAL  = 8'h11;
    localparam logic [7:0] OFF_MASK    = 8'h12;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam int         OP_PAUSE_BIT  = 7;
    localparam int         OP_TRIG_HI    = 6;
    localparam int         OP_TRIG_LO    = 5;
    localparam int         OP_OSC_BIT    = 4;
    localparam int         OP_DIV_HI     = 3;
    localparam int         OP_DIV_LO     = 0;
    localparam int         SCAN_RUN_BIT  = 4;
    localparam int         SCAN_MTH_HI   = 1;
    localparam int         SCAN_MTH_LO   = 0;
    localparam int         STATUS_FLAG   = 0;
    localparam logic [7:0] SCAN_WR_MASK  = 8'h13;
    localparam logic [7:0] MANUAL_WR_MASK = 8'h0f;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] TRIG_HOST     = 2'h0;
    localparam logic [1:0] TRIG_AUTO     = 2'h1;
    localparam logic [1:0] METHOD_MANUAL = 2'h0;
    localparam logic [1:0] METHOD_AUTO   = 2'h1;
    localparam logic [1:0] METHOD_FLY    = 2'h2;
    localparam logic [7:0] REG_RESET     = 8'h00;

    typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_HOLD} scan_state_t;

endpackage

/* File: src/pin_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* File: src/channel_scanner.sv */
// Channel sequencer: manual pick or ascending walk over the scan mask
`timescale 1ns/1ps
module channel_scanner
    import adc_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        run,
    input  wire logic                        hold,
    input  wire logic [1:0]                  method,
    input  wire logic [3:0]                  manual_id,
    input  wire logic [CHANNELS-1:0]         mask,
    input  wire logic                        conv_done,
    output logic      [$clog2(CHANNELS)-1:0] channel_q,
    output logic                             active_q
);
    localparam int CW = $clog2(CHANNELS);

    scan_state_t state_q;

    // Next mask channel above cur, wrapping
    function automatic logic [CW-1:0] next_ch(input logic [CW-1:0] cur,
                                              input logic [CHANNELS-1:0] m,
                                              input logic from_start);
        logic [CW-1:0] res;
        logic          found;
        int            idx;
        res   = cur;
        found = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
        begin
            idx = from_start ? i : (int'(cur) + 1 + i) % CHANNELS;
            if (!found && m[idx])
            begin
                res   = CW'(idx);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q   <= SCAN_IDLE;
            channel_q <= '0;
            active_q  <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                SCAN_IDLE:
                begin
                    if (method == METHOD_MANUAL)
                        channel_q <= manual_id[CW-1:0];
                    if (run && |mask && !hold)                  // RL11
                    begin
                        state_q   <= SCAN_RUN;
                        channel_q <= next_ch('0, mask, 1'b1);
                        active_q  <= 1'b1;
                    end
                end
                SCAN_RUN:
                begin
                    if (!run)                                   // RL11
                    begin
                        state_q  <= SCAN_IDLE;
                        active_q <= 1'b0;
                    end
                    else if (hold)                              // RL2
                    begin
                        state_q  <= SCAN_HOLD;
                        active_q <= 1'b0;
                    end
                    else if (conv_done)                         // RL11
                        channel_q <= next_ch(channel_q, mask, 1'b0);
                end
                SCAN_HOLD:
                begin
                    // Resume where the pause caught us
                    if (!run)
                        state_q <= SCAN_IDLE;
                    else if (!hold)                             // RL2
                    begin
                        state_q  <= SCAN_RUN;
                        active_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q  <= SCAN_IDLE;
                    active_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: src/adc_mode_gpio_config_regs.sv */
// Mode, pin function and scan configuration bank behind a serial port
//
// Behaviour
// RL1: Pause bit clear: errors leave scanning, pins alone
// RL2: Pause bit set: error forces analog, holds scan
// RL3: Trigger field 00 host, 01 autonomous conversions
// RL4: Timing source bit: 0 fast, 1 low power
// RL5: Four-bit divider sets autonomous sampling speed
// RL6: Channel function bit: 0 analog, 1 digital
// RL7: Direction bit: 0 digital input, 1 output
// RL8: Drive bit: 0 open-drain, 1 push-pull
// RL9: Level bit sets driven output level
// RL10: Input level register read-only, shows pins
// RL11: Scan run starts ascending masked scan, 0 stops; code starts it only with scan method auto and a nonzero mask
// RL12: Scan register reserved bits read zero
// RL13: Every register clears to zero on reset
// RL14: Scan method: manual, auto, on-the-fly, reserved
// RL15: Inbound check error sets sticky flag
// RL16: Pin driven only as configured digital output
`timescale 1ns/1ps
module adc_mode_gpio_config_regs
    import adc_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        cs_n,
    input  wire logic                        sclk,
    input  wire logic                        sdi,
    output logic                             sdo,
    output logic                             sdo_oe,
    input  wire logic [CHANNELS-1:0]         gpio_in,
    output logic      [CHANNELS-1:0]         gpio_out,
    output logic      [CHANNELS-1:0]         gpio_oe,
    output logic      [CHANNELS-1:0]         channel_is_gpio,
    input  wire logic                        crc_error,
    input  wire logic                        conv_done,
    output logic                             crc_fail_flag,
    output logic                             conv_autonomous,
    output logic                             osc_low_power,
    output logic      [3:0]                  sample_rate_div,
    output logic      [1:0]                  scan_method,
    output logic                             scan_active,
    output logic      [$clog2(CHANNELS)-1:0] active_channel
);
    localparam int CW = $clog2(CHANNELS);

    generate
        if (CHANNELS < 2 || CHANNELS > 8)
        begin : g_bad_width
            $error("CHANNELS out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0]          link_sync;
    logic [CHANNELS-1:0] gpio_sync;

    pin_sync #(.WIDTH(3)) u_link_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, sclk, sdi}),
        .q   (link_sync)
    );

    pin_sync #(.WIDTH(CHANNELS)) u_gpio_sync (
        .clk (clk),
        .rst (rst),
        .d   (gpio_in),
        .q   (gpio_sync)
    );

    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_n_s    = link_sync[2];
    assign sclk_s    = link_sync[1];
    assign sdi_s     = link_sync[0];
    assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_q;
    assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]          opmode_q;
    logic [CHANNELS-1:0] pin_func_q;
    logic [CHANNELS-1:0] dir_q;
    logic [CHANNELS-1:0] drive_q;
    logic [CHANNELS-1:0] level_q;
    logic [CHANNELS-1:0] input_level_q;
    logic [7:0]          scan_cfg_q;
    logic [3:0]          manual_id_q;
    logic [CHANNELS-1:0] mask_q;
    logic                flag_q;

    // ----------------------------------------------------------------
    // Serial frame: opcode, address, data; mode 0, MSB first
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] bit_cnt_q;
    logic [15:0]      hdr_q;
    logic [7:0]       wdata_q;
    logic [7:0]       out_q;
    logic             wr_strobe;
    logic [7:0]       wr_addr;
    logic [7:0]       wr_data;

    // Read view; unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            OFF_STATUS: v[STATUS_FLAG] = flag_q;
            OFF_OPMODE: v = opmode_q;
            OFF_PIN:    v[CHANNELS-1:0] = pin_func_q;
            OFF_DIR:    v[CHANNELS-1:0] = dir_q;
            OFF_DRIVE:  v[CHANNELS-1:0] = drive_q;
            OFF_LEVEL:  v[CHANNELS-1:0] = level_q;
            OFF_INPUT:  v[CHANNELS-1:0] = input_level_q;
            OFF_SCAN:   v = scan_cfg_q & SCAN_WR_MASK;           // RL12
            OFF_MANUAL: v[3:0] = manual_id_q;
            OFF_MASK:   v[CHANNELS-1:0] = mask_q;
            default:    v = 8'h00;
        endcase
        return v;
    endfunction

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_q <= '0;
            hdr_q     <= '0;
            wdata_q   <= '0;
        end
        else if (cs_n_s)
        begin
            // Idle between frames
            bit_cnt_q <= '0;
        end
        else if (sclk_rise)
        begin
            if (bit_cnt_q <= CNT_HDR_END)
                hdr_q <= {hdr_q[14:0], sdi_s};
            else
                wdata_q <= {wdata_q[6:0], sdi_s};
            if (bit_cnt_q != CNT_LAST)
                bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // Read byte loads after header, shifts out on falls
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_q <= '0;
            sdo   <= 1'b0;
        end
        else if (cs_n_s)
        begin
            out_q <= '0;
            sdo   <= 1'b0;
        end
        else if (sclk_rise && bit_cnt_q == CNT_HDR_END)
        begin
            if (hdr_q[14:7] == CMD_READ)
                out_q <= read_reg({hdr_q[6:0], sdi_s});
            else
                out_q <= 8'h00;
        end
        else if (sclk_fall && bit_cnt_q > CNT_HDR_END)
        begin
            sdo   <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sdo_oe <= 1'b0;
        else
            sdo_oe <= !cs_n_s;
    end

    // Last data bit commits a write
    assign wr_strobe = sclk_rise && bit_cnt_q == CNT_LAST
                       && hdr_q[15:8] == CMD_WRITE;
    assign wr_addr   = hdr_q[7:0];
    assign wr_data   = {wdata_q[6:0], sdi_s};

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            opmode_q    <= REG_RESET;                           // RL13
            pin_func_q  <= '0;
            dir_q       <= '0;
            drive_q     <= '0;
            level_q     <= '0;
            scan_cfg_q  <= REG_RESET;
            manual_id_q <= '0;
            mask_q      <= '0;
        end
        else if (wr_strobe)
        begin
            unique case (wr_addr)
                OFF_OPMODE: opmode_q    <= wr_data;
                OFF_PIN:    pin_func_q  <= wr_data[CHANNELS-1:0];
                OFF_DIR:    dir_q       <= wr_data[CHANNELS-1:0];
                OFF_DRIVE:  drive_q     <= wr_data[CHANNELS-1:0];
                OFF_LEVEL:  level_q     <= wr_data[CHANNELS-1:0];
                OFF_SCAN:   scan_cfg_q  <= wr_data & SCAN_WR_MASK; // RL12
                OFF_MANUAL: manual_id_q <= wr_data[3:0] & MANUAL_WR_MASK[3:0];
                OFF_MASK:   mask_q      <= wr_data[CHANNELS-1:0];
                default:    ;
            endcase
        end
    end

    // Read-only: host writes cannot reach it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            input_level_q <= '0;
        else
            input_level_q <= gpio_sync;                         // RL10
    end

    // ----------------------------------------------------------------
    // Inbound check flag: write one to clear, a new error wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_q <= 1'b0;
        else if (crc_error)
            flag_q <= 1'b1;                                     // RL15
        else if (wr_strobe && wr_addr == OFF_STATUS
                 && wr_data[STATUS_FLAG])
            flag_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic                paused;
    logic [1:0]          trig;
    logic [1:0]          method;
    logic [CHANNELS-1:0] eff_func;
    logic                scan_run_req;

    // Pause only bites when enabled; otherwise the flag is advisory
    assign paused       = opmode_q[OP_PAUSE_BIT] && flag_q;    // RL1 RL2
    assign eff_func     = paused ? '0 : pin_func_q;            // RL2 RL6
    assign trig         = opmode_q[OP_TRIG_HI:OP_TRIG_LO];
    assign method       = scan_cfg_q[SCAN_MTH_HI:SCAN_MTH_LO];
    assign scan_run_req = scan_cfg_q[SCAN_RUN_BIT]
                          && method == METHOD_AUTO;             // RL11 RL14

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            conv_autonomous <= 1'b0;
            osc_low_power   <= 1'b0;
            sample_rate_div <= '0;
            scan_method     <= METHOD_MANUAL;
            crc_fail_flag   <= 1'b0;
            channel_is_gpio <= '0;
        end
        else
        begin
            conv_autonomous <= trig == TRIG_AUTO && !paused;   // RL3
            osc_low_power   <= opmode_q[OP_OSC_BIT];           // RL4
            sample_rate_div <= opmode_q[OP_DIV_HI:OP_DIV_LO];  // RL5
            scan_method     <= method;                         // RL14
            crc_fail_flag   <= flag_q;
            channel_is_gpio <= eff_func;                       // RL6
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_pin
            logic drive_en;

            assign drive_en = eff_func[g] && dir_q[g];         // RL7 RL16

            // Open-drain pulls low only; the pull-up makes high
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g]  <= 1'b0;
                end
                else if (!drive_en)
                begin
                    gpio_out[g] <= 1'b0;
                    gpio_oe[g]  <= 1'b0;                       // RL16
                end
                else if (drive_q[g])
                begin
                    gpio_out[g] <= level_q[g];                 // RL8 RL9
                    gpio_oe[g]  <= 1'b1;
                end
                else
                begin
                    gpio_out[g] <= 1'b0;                       // RL8
                    gpio_oe[g]  <= !level_q[g];                // RL9
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Channel sequencing
    // ----------------------------------------------------------------
    logic [CW-1:0] scan_ch;
    logic          scan_on;

    channel_scanner #(.CHANNELS(CHANNELS)) u_scanner (
        .clk       (clk),
        .rst       (rst),
        .run       (scan_run_req),
        .hold      (paused),
        .method    (method),
        .manual_id (manual_id_q),
        .mask      (mask_q),
        .conv_done (conv_done),
        .channel_q (scan_ch),
        .active_q  (scan_on)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scan_active    <= 1'b0;
            active_channel <= '0;
        end
        else
        begin
            scan_active    <= scan_on;                         // RL11
            active_channel <= scan_ch;
        end
    end

endmodule

/* File: dv/adc_cfg_asserts.sv */
// Port checker for the configuration bank
`timescale 1ns/1ps
module adc_cfg_asserts
    import adc_cfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        cs_n,
    input wire logic                        crc_error,
    input wire logic                        conv_done,
    input wire logic [CHANNELS-1:0]         gpio_oe,
    input wire logic [CHANNELS-1:0]         channel_is_gpio,
    input wire logic                        crc_fail_flag,
    input wire logic                        osc_low_power,
    input wire logic [3:0]                  sample_rate_div,
    input wire logic [1:0]                  scan_method,
    input wire logic                        scan_active,
    input wire logic [$clog2(CHANNELS)-1:0] active_channel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_OE_GPIO: assert property (~|(gpio_oe & ~channel_is_gpio))
        else $error("pin driven while analog");
    AST_RST_CLR: assert property ($fell(rst) |-> !(|gpio_oe)
        && !scan_active && !crc_fail_flag && !(|channel_is_gpio))
        else $error("reset not clear");
    AST_FLAG_SET: assert property (crc_error |-> ##[1:2] crc_fail_flag)
        else $error("flag not set");
    AST_FLAG_HOLD: assert property (crc_fail_flag && cs_n |=> crc_fail_flag)
        else $error("flag lost");
    AST_CFG_STABLE: assert property (cs_n[*8] |-> $stable(osc_low_power)
        && $stable(sample_rate_div) && $stable(scan_method))
        else $error("mode moved");
    AST_PIN_STABLE: assert property ((cs_n && !crc_error)[*6] |->
        $stable(channel_is_gpio) && $stable(gpio_oe))
        else $error("pins moved");
    AST_SCAN_AUTO: assert property (scan_active |-> scan_method == METHOD_AUTO)
        else $error("scan not auto");
    AST_SCAN_STEADY: assert property ((scan_active && !conv_done)[*8]
        |-> $stable(active_channel))
        else $error("scan stepped");

    COV_PAUSE: cover property ($rose(crc_fail_flag) && !(|channel_is_gpio));
    COV_SCAN: cover property (scan_active && conv_done);
    COV_DRIVE: cover property (&gpio_oe);
endmodule

bind adc_mode_gpio_config_regs adc_cfg_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

/* File: dv/spi_host_model.sv */
// Serial host model issuing mode-0 frames
`timescale 1ns/1ps
module spi_host_model
    import adc_cfg_pkg::*;
(
    input  wire logic       clk,
    output logic            cs_n,
    output logic            sclk,
    output logic            sdi,
    input  wire logic       sdo,
    input  wire logic       sdo_oe,
    output logic [7:0]      rd_data,
    output logic            rd_valid
);
    localparam int HALF = 16;

    initial
    begin
        {cs_n, sclk, sdi, rd_valid} = 4'b1000;
        rd_data = 8'h00;
    end

    task automatic xfer(input logic [7:0] op, adr, wd);
        logic [23:0] f;
        f = {op, adr, wd};
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdi = f[i];
            repeat (HALF) @(negedge clk);
            // Parked output reads as unknown
            if (i < 8) rd_data[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1'b1;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        // Released line flips so no check rides on a held level
        sdi = ~sdi;
        rd_valid = (op == CMD_READ);
        @(negedge clk);
        rd_valid = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* File: dv/adc_mode_gpio_config_regs_tb.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module adc_mode_gpio_config_regs_tb
    import adc_cfg_pkg::*;
;
    logic       clk, rst, crc_error, conv_done, cs_n, sclk, sdi;
    logic       sdo, sdo_oe, rd_valid, crc_fail_flag, conv_autonomous;
    logic       osc_low_power, scan_active;
    logic [7:0] gpio_in, gpio_out, gpio_oe, channel_is_gpio, rd_data;
    logic [7:0] fn, dir, pp, lvl, ext, v;
    logic [3:0] sample_rate_div;
    logic [1:0] scan_method;
    logic [2:0] active_channel;
    logic [7:0] exp_q[$];
    int         n_mismatch = 0;
    int         total_checks = 0;
    localparam logic [7:0] RESET_OFFS [8] = '{OFF_STATUS, OFF_OPMODE,
        OFF_PIN, OFF_DIR, OFF_DRIVE, OFF_LEVEL, OFF_INPUT, OFF_SCAN};
    localparam logic [7:0] WALK [4] = '{8'h02, 8'h05, 8'h07, 8'h02};

    adc_mode_gpio_config_regs #(.CHANNELS(8)) dut (
        .clk, .rst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe, .gpio_in,
        .gpio_out, .gpio_oe, .channel_is_gpio, .crc_error, .conv_done,
        .crc_fail_flag, .conv_autonomous, .osc_low_power,
        .sample_rate_div, .scan_method, .scan_active, .active_channel);
    spi_host_model u_host (.clk, .cs_n, .sclk, .sdi, .sdo, .sdo_oe,
        .rd_data, .rd_valid);

    // Undriven pins: outside source, pull-up on open-drain
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & (ext | fn & dir & ~pp));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, e);
        total_checks++;
        if (seen !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.xfer(CMD_WRITE, a, d);
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        u_host.xfer(CMD_READ, a, 8'h00);
    endtask
    task automatic cfg();
        wr(OFF_PIN, fn);
        wr(OFF_DIR, dir);
        wr(OFF_DRIVE, pp);
        wr(OFF_LEVEL, lvl);
    endtask
    task automatic strobe(input bit err);
        @(negedge clk);
        {crc_error, conv_done} = {err, !err};
        @(negedge clk);
        {crc_error, conv_done} = 2'b00;
        repeat (8) @(negedge clk);
    endtask
    task automatic pins();
        logic [7:0] oe, out;
        oe = fn & dir & (pp | ~lvl);
        out = fn & dir & pp & lvl;
        chk("oe", gpio_oe, oe);
        chk("out", gpio_out & oe, out);
        chk("func", channel_is_gpio, fn);
        rd(OFF_INPUT, out | (~oe & (ext | fn & dir & ~pp)));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk)
        if (rd_valid === 1'b1)
            chk("rdata", rd_data, exp_q.pop_front());

    initial
    begin
        #400_000;
        n_mismatch++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hcc741fd9));
        rst = 1'b1;
        {crc_error, conv_done, fn, dir, pp, lvl, ext} = '0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        foreach (RESET_OFFS[i]) rd(RESET_OFFS[i], 8'h00);
        rd(8'h3f, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            {fn, dir, pp, lvl, ext} = 40'({$urandom, $urandom});
            cfg();
            wr(OFF_INPUT, ~ext);
            rd(OFF_PIN, fn);
            rd(OFF_DIR, dir);
            rd(OFF_DRIVE, pp);
            rd(OFF_LEVEL, lvl);
            pins();
        end
        for (int t = 0; t < 4; t++)
        begin
            v = {1'b0, 2'(t), 5'($urandom)};
            wr(OFF_OPMODE, v);
            rd(OFF_OPMODE, v);
            chk("auto", 8'(conv_autonomous), 8'(t == 1));
            chk("osc", 8'(osc_low_power), 8'(v[4]));
            chk("div", 8'(sample_rate_div), 8'(v[3:0]));
        end
        wr(OFF_MANUAL, 8'hf6);
        rd(OFF_MANUAL, 8'h06);
        wr(OFF_MASK, 8'ha4);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_SCAN, 8'hfc | 8'(m));
            rd(OFF_SCAN, 8'h10 | 8'(m));
            chk("meth", 8'(scan_method), 8'(m));
            chk("run", 8'(scan_active), 8'(m == 1));
            if (m == 0) chk("man", 8'(active_channel), 8'h06);
            if (m == 1)
                foreach (WALK[j])
                begin
                    chk("step", 8'(active_channel), WALK[j]);
                    strobe(1'b0);
                end
            wr(OFF_SCAN, 8'(m));
            chk("stop", 8'(scan_active), 8'h00);
        end
        {fn, dir, pp, lvl} = 32'hffffff5a;
        cfg();
        wr(OFF_OPMODE, 8'h20);
        strobe(1'b1);
        chk("flag", 8'(crc_fail_flag), 8'h01);
        chk("auto", 8'(conv_autonomous), 8'h01);
        pins();
        rd(OFF_STATUS, 8'h01);
        wr(OFF_STATUS, 8'h01);
        chk("clr", 8'(crc_fail_flag), 8'h00);
        wr(OFF_OPMODE, 8'ha0);
        strobe(1'b1);
        chk("pause", channel_is_gpio | gpio_oe, 8'h00);
        chk("hold", 8'(conv_autonomous), 8'h00);
        wr(OFF_STATUS, 8'h01);
        pins();
        conclude();
    end
endmodule
